// ---- adhr_cfg.svh ----
// Constants for the converter run control and handshake sequencer.
// Assumes inclusion by bare name from the package and design modules.
`ifndef ADHR_CFG_SVH
`define ADHR_CFG_SVH

// *****
// Converter variant and phase lengths
// *****
`define ADHR_RES_BITS_DEF      16
`define ADHR_INT_COUNTS_DEF    32768
`define ADHR_DEINT_COUNTS_DEF  65536
`define ADHR_AZ_MIN_COUNTS_DEF 32768
`define ADHR_BYTE_BITS         8
`define ADHR_MAX_BYTES         3
`define ADHR_EXTRA_BITS        2

// *****
// Register map
// *****
`define ADHR_ADDR_W            12
`define ADHR_CTRL_OFF          12'h000
`define ADHR_STATUS_OFF        12'h004
`define ADHR_RESULT_OFF        12'h008
`define ADHR_CTRL_MODE_BIT     0
`define ADHR_CTRL_RH_BIT       1
`define ADHR_CTRL_RST          2'h0
`define ADHR_ST_HS_BIT         0
`define ADHR_ST_STATUS_BIT     1
`define ADHR_ST_PHASE_LO       2
`define ADHR_ST_PHASE_HI       3

`endif

// ---- adhr_pkg.sv ----
// Types shared by the run control and the handshake sequencer.
// Assumes adhr_cfg.svh is on the include path.
`include "adhr_cfg.svh"

package adhr_pkg;

    // *****
    // State encodings
    // *****
    typedef enum logic [1:0] {
        PH_AZ_IDLE = 2'h0,
        PH_INT     = 2'h1,
        PH_DEINT   = 2'h3,
        PH_AZ      = 2'h2
    } adhr_phase_type;

    typedef enum logic [2:0] {
        HS_IDLE   = 3'h0,
        HS_WAIT   = 3'h1,
        HS_STROBE = 3'h3,
        HS_HOLD   = 3'h2,
        HS_FLOAT  = 3'h6
    } adhr_hs_state_type;

    // *****
    // Carriers
    // *****
    typedef struct packed {
        logic run_hold;
        logic mode;
    } adhr_ctrl_type;

    typedef struct packed {
        logic cmp;
        logic ready;
        logic run_hold;
        logic mode;
    } adhr_pins_type;

endpackage : adhr_pkg

// ---- adhr_handshake_seq.sv ----
// Handshake sequencer: sends the latched result byte by byte.
// Assumes synchronised ready and mode, and a result held in flops.
`timescale 1ns/10ps
`include "adhr_cfg.svh"

module adhr_handshake_seq
    import adhr_pkg::*;
#(
    parameter int DW = `ADHR_RES_BITS_DEF + `ADHR_EXTRA_BITS,
    parameter int NB = (DW + `ADHR_BYTE_BITS - 1) / `ADHR_BYTE_BITS
)(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic     ce,
    input  wire logic     mode,
    input  wire logic     ready,
    input  wire logic     latch_pulse,
    output logic          hs_active,
    output logic [DW-1:0] data_oe,
    output logic [NB-1:0] byte_dis_n_out,
    output logic [NB-1:0] byte_dis_oe,
    output logic          load_strobe_n_out,
    output logic          load_strobe_oe
);

    localparam int IW = (NB > 1) ? $clog2(NB) : 1;
    localparam logic [IW-1:0] LAST_IDX = IW'(NB - 1);

    adhr_hs_state_type state_reg;
    logic [IW-1:0]     idx_reg;
    logic [NB-1:0]     byte_oe_reg;
    logic [NB-1:0]     byte_dis_n_reg;
    logic              strobe_n_reg;
    logic              mode_prev_reg;
    logic              enter;

    if (NB < 2 || NB > `ADHR_MAX_BYTES) begin : g_bad_nb
        $error("adhr_handshake_seq: byte count must be 2 or 3");
    end

    // *****
    // Entry
    // *****
    // Rise during a latch cycle is served by the latch term, so it enters at its end
    assign enter = (state_reg == HS_IDLE) &&
                   ((latch_pulse && mode) ||
                    (mode && !mode_prev_reg));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_prev_reg <= 1'b0;
        end else if (ce) begin
            mode_prev_reg <= mode;
        end
    end

    // *****
    // Byte sequence
    // *****
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg      <= HS_IDLE;
            idx_reg        <= '0;
            byte_oe_reg    <= '0;
            byte_dis_n_reg <= '1;
            strobe_n_reg   <= 1'b1;
        end else if (ce) begin
            case (state_reg)
                HS_IDLE: begin
                    if (enter) begin
                        state_reg <= HS_WAIT;
                        idx_reg   <= '0;
                    end
                end
                HS_WAIT: begin
                    if (ready) begin
                        byte_dis_n_reg[idx_reg] <= 1'b0;
                        byte_oe_reg[idx_reg]    <= 1'b1;
                        strobe_n_reg            <= 1'b0;
                        state_reg               <= HS_STROBE;
                    end
                end
                HS_STROBE: begin
                    strobe_n_reg <= 1'b1;
                    state_reg    <= HS_HOLD;
                end
                HS_HOLD: begin
                    // Busy receiver keeps ready low, so the byte stays driven
                    if (ready) begin
                        byte_oe_reg[idx_reg] <= 1'b0;
                        state_reg            <= HS_FLOAT;
                    end
                end
                HS_FLOAT: begin
                    byte_dis_n_reg[idx_reg] <= 1'b1;
                    if (idx_reg == LAST_IDX) begin
                        state_reg <= HS_IDLE;
                    end else begin
                        idx_reg   <= idx_reg + 1'b1;
                        state_reg <= HS_WAIT;
                    end
                end
                default: begin
                    state_reg <= HS_IDLE;
                end
            endcase
        end
    end

    // *****
    // Pin drive
    // *****
    assign hs_active = (state_reg != HS_IDLE);

    // Outside a transfer the pins float on pull-ups unless mode is high
    assign byte_dis_oe       = {NB{hs_active || mode}};
    assign load_strobe_oe    = hs_active || mode;
    assign byte_dis_n_out    = byte_dis_n_reg;
    assign load_strobe_n_out = strobe_n_reg;

    for (genvar b = 0; b < DW; b++) begin : g_oe
        assign data_oe[b] = byte_oe_reg[b / `ADHR_BYTE_BITS];
    end

endmodule : adhr_handshake_seq

// ---- adhr_run_control.sv ----
// Run/hold sequencer, result latch, APB and byte handshake.
// Assumes one 100 MHz clock and asynchronous pins;
// disable pin pull-ups sit off chip.
//
// Function
// - Latch with mode high enters handshake after latch
// - Mode rising edge enters handshake, after any latch
// - Handshake blocks latching, ignores mode, conversions continue
// - Disable pins become driven handshake outputs
// - Ready high enables next byte, disable low
// - Load strobe low exactly one clock per byte
// - Ready high floats active byte data outputs
// - Then disable high, next byte follows
// - Three bytes full width, two otherwise
// - Byte data driven while its disable low
// - Final acknowledge ends handshake, latching resumes
// - After exit with mode low, pins float
// - Mode high: each conversion starts a transfer
// - Run/hold high gives fixed cycle length
// - Run/hold low after crossing ends reference phase
// - Then minimum auto-zero, wait for run/hold
// - Run/hold high at minimum starts next conversion
// - Run/hold low finishes current, starts none
// - Latch clock after crossing, status then falls
// - Input integrate lasts fixed count
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps
`include "adhr_cfg.svh"

module adhr_run_control
    import adhr_pkg::*;
#(
    parameter int RES_BITS      = `ADHR_RES_BITS_DEF,
    parameter int INT_COUNTS    = `ADHR_INT_COUNTS_DEF,
    parameter int DEINT_COUNTS  = `ADHR_DEINT_COUNTS_DEF,
    parameter int AZ_MIN_COUNTS = `ADHR_AZ_MIN_COUNTS_DEF
)(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      ce,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`ADHR_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      mode_in,
    input  wire logic                      run_hold_in,
    input  wire logic                      comparator_in,
    input  wire logic                      receiver_ready_in,
    output logic                           conversion_status_out,
    output logic                           phase_az_out,
    output logic                           phase_int_out,
    output logic                           phase_deint_out,
    output logic      [RES_BITS+1:0]       data_out,
    output logic      [RES_BITS+1:0]       data_oe,
    output logic      [(RES_BITS+9)/8-1:0] byte_dis_n_out,
    output logic      [(RES_BITS+9)/8-1:0] byte_dis_oe,
    output logic                           chip_off_load_strobe_n,
    output logic                           chip_off_load_strobe_oe
);

    localparam int DW    = RES_BITS + `ADHR_EXTRA_BITS;
    localparam int NB    = (DW + `ADHR_BYTE_BITS - 1) / `ADHR_BYTE_BITS;
    localparam int TOTAL = INT_COUNTS + DEINT_COUNTS + AZ_MIN_COUNTS;
    localparam int CW    = $clog2(TOTAL + 1);
    localparam logic [CW-1:0] INT_L   = CW'(INT_COUNTS);
    localparam logic [CW-1:0] DEINT_L = CW'(DEINT_COUNTS);
    localparam logic [CW-1:0] AZ_L    = CW'(AZ_MIN_COUNTS);
    localparam logic [CW-1:0] ONE_L   = CW'(1);

    // *****
    // Elaboration checks
    // *****
    if (RES_BITS != 12 && RES_BITS != 14 && RES_BITS != 16) begin : g_bad_res
        $error("adhr_run_control: resolution must be 12, 14 or 16");
    end
    if (INT_COUNTS < 2 || AZ_MIN_COUNTS < 2 || DEINT_COUNTS < 2 ||
        DEINT_COUNTS > (1 << RES_BITS)) begin : g_bad_cnt
        $error("adhr_run_control: phase counts out of range");
    end

    // *****
    // Pin synchronisers
    // *****
    adhr_pins_type pins_meta_reg;
    adhr_pins_type pins_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_meta_reg <= '0;
            pins_reg      <= '0;
        end else if (ce) begin
            pins_meta_reg <= '{cmp: comparator_in, ready: receiver_ready_in,
                               run_hold: run_hold_in, mode: mode_in};
            pins_reg      <= pins_meta_reg;
        end
    end

    // *****
    // Control register and effective inputs
    // *****
    adhr_ctrl_type ctrl_reg;
    logic          mode_eff;
    logic          run_hold_eff;

    // Software bits OR with the pins, so either source can request
    assign mode_eff     = pins_reg.mode || ctrl_reg.mode;
    assign run_hold_eff = pins_reg.run_hold || ctrl_reg.run_hold;

    // *****
    // Conversion sequencer
    // *****
    adhr_phase_type      phase_reg;
    logic [CW-1:0]       left_reg;
    logic                polarity_reg;
    logic [RES_BITS-1:0] mag_hold_reg;
    logic                over_hold_reg;
    logic                latch_req_reg;
    logic                zc;
    logic [CW-1:0]       deint_count;

    assign zc          = (pins_reg.cmp != polarity_reg);
    assign deint_count = DEINT_L - left_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg     <= PH_AZ_IDLE;
            left_reg      <= '0;
            polarity_reg  <= 1'b0;
            mag_hold_reg  <= '0;
            over_hold_reg <= 1'b0;
            latch_req_reg <= 1'b0;
        end else if (ce) begin
            latch_req_reg <= 1'b0;
            case (phase_reg)
                PH_AZ_IDLE: begin
                    if (run_hold_eff) begin
                        phase_reg <= PH_INT;
                        left_reg  <= INT_L;
                    end
                end
                PH_INT: begin
                    left_reg <= left_reg - ONE_L;
                    if (left_reg == ONE_L) begin
                        polarity_reg <= pins_reg.cmp;
                        phase_reg    <= PH_DEINT;
                        left_reg     <= DEINT_L;
                    end
                end
                PH_DEINT: begin
                    left_reg <= left_reg - ONE_L;
                    if (zc) begin
                        mag_hold_reg  <= deint_count[RES_BITS-1:0];
                        over_hold_reg <= 1'b0;
                        latch_req_reg <= 1'b1;
                        phase_reg     <= PH_AZ;
                        // Unused reference slot joins auto-zero for a fixed cycle
                        left_reg      <= left_reg - ONE_L + AZ_L;
                    end else if (left_reg == ONE_L) begin
                        mag_hold_reg  <= '1;
                        over_hold_reg <= 1'b1;
                        latch_req_reg <= 1'b1;
                        phase_reg     <= PH_AZ;
                        left_reg      <= AZ_L;
                    end
                end
                PH_AZ: begin
                    if (!run_hold_eff && left_reg > AZ_L) begin
                        left_reg <= AZ_L - ONE_L;
                    end else if (left_reg == ONE_L) begin
                        if (run_hold_eff) begin
                            phase_reg <= PH_INT;
                            left_reg  <= INT_L;
                        end else begin
                            phase_reg <= PH_AZ_IDLE;
                            left_reg  <= '0;
                        end
                    end else begin
                        left_reg <= left_reg - ONE_L;
                    end
                end
                default: begin
                    phase_reg <= PH_AZ_IDLE;
                end
            endcase
        end
    end

    // *****
    // Result latch and status
    // *****
    logic          hs_active;
    logic          latch_pulse;
    logic [DW-1:0] result_reg;
    logic          status_reg;

    // Handshake holds the old word, so a transfer never mixes two results
    assign latch_pulse = latch_req_reg && !hs_active;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= '0;
        end else if (ce && latch_pulse) begin
            result_reg <= {over_hold_reg, polarity_reg, mag_hold_reg};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 1'b0;
        end else if (ce) begin
            if (phase_reg != PH_INT && phase_reg != PH_DEINT &&
                run_hold_eff && (phase_reg == PH_AZ_IDLE || left_reg == ONE_L)) begin
                status_reg <= 1'b1;
            end else if (latch_req_reg) begin
                // Falls on the latch edge itself; single-edge design
                status_reg <= 1'b0;
            end
        end
    end

    assign conversion_status_out = status_reg;
    assign phase_az_out          = (phase_reg == PH_AZ) || (phase_reg == PH_AZ_IDLE);
    assign phase_int_out         = (phase_reg == PH_INT);
    assign phase_deint_out       = (phase_reg == PH_DEINT);
    assign data_out              = result_reg;

    // *****
    // Handshake sequencer
    // *****
    adhr_handshake_seq #(
        .DW (DW),
        .NB (NB)
    ) u_hs (
        .pclk              (pclk),
        .presetn           (presetn),
        .ce                (ce),
        .mode              (mode_eff),
        .ready             (pins_reg.ready),
        .latch_pulse       (latch_pulse),
        .hs_active         (hs_active),
        .data_oe           (data_oe),
        .byte_dis_n_out    (byte_dis_n_out),
        .byte_dis_oe       (byte_dis_oe),
        .load_strobe_n_out (chip_off_load_strobe_n),
        .load_strobe_oe    (chip_off_load_strobe_oe)
    );

    // *****
    // APB slave
    // *****
    logic        setup;
    logic        access;
    logic        addr_ok;
    logic [31:0] rd_word;
    logic [31:0] prdata_reg;

    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign addr_ok = (paddr == `ADHR_CTRL_OFF) || (paddr == `ADHR_STATUS_OFF) ||
                     (paddr == `ADHR_RESULT_OFF);

    always_comb begin
        rd_word = '0;
        case (paddr)
            `ADHR_CTRL_OFF: begin
                rd_word[`ADHR_CTRL_MODE_BIT] = ctrl_reg.mode;
                rd_word[`ADHR_CTRL_RH_BIT]   = ctrl_reg.run_hold;
            end
            `ADHR_STATUS_OFF: begin
                rd_word[`ADHR_ST_HS_BIT]     = hs_active;
                rd_word[`ADHR_ST_STATUS_BIT] = status_reg;
                rd_word[`ADHR_ST_PHASE_HI:`ADHR_ST_PHASE_LO] = phase_reg;
            end
            `ADHR_RESULT_OFF: begin
                rd_word[DW-1:0] = result_reg;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // Read data captured in setup, so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (ce && setup) begin
            prdata_reg <= rd_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `ADHR_CTRL_RST;
        end else if (ce && access && pwrite && paddr == `ADHR_CTRL_OFF) begin
            ctrl_reg.mode     <= pwdata[`ADHR_CTRL_MODE_BIT];
            ctrl_reg.run_hold <= pwdata[`ADHR_CTRL_RH_BIT];
        end
    end

    // Frozen clock enable stalls the bus rather than dropping a transfer
    assign pready  = ce;
    assign pslverr = access && !addr_ok;
    assign prdata  = prdata_reg;

endmodule : adhr_run_control

// ---- adhr_run_control_props.sv ----
// Port assertions for the run control and byte handshake.
// Assumes one clock domain; bound onto every run control instance.
`timescale 1ns/10ps
`include "adhr_cfg.svh"

module adhr_rc_props
    import adhr_pkg::*;
#(
    parameter int RES_BITS      = `ADHR_RES_BITS_DEF,
    parameter int INT_COUNTS    = `ADHR_INT_COUNTS_DEF,
    parameter int DEINT_COUNTS  = `ADHR_DEINT_COUNTS_DEF,
    parameter int AZ_MIN_COUNTS = `ADHR_AZ_MIN_COUNTS_DEF
)(
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      receiver_ready_in,
    input wire logic                      conversion_status_out,
    input wire logic                      phase_az_out,
    input wire logic                      phase_int_out,
    input wire logic                      phase_deint_out,
    input wire logic [RES_BITS+1:0]       data_oe,
    input wire logic [(RES_BITS+9)/8-1:0] byte_dis_n_out,
    input wire logic [(RES_BITS+9)/8-1:0] byte_dis_oe,
    input wire logic                      chip_off_load_strobe_n,
    input wire logic                      chip_off_load_strobe_oe
);
    // *****
    // Phase counters
    // *****
    int   int_cnt, deint_cnt, az_cnt;
    logic conv_seen;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_cnt   <= 0;
            deint_cnt <= 0;
            az_cnt    <= 0;
            conv_seen <= 1'b0;
        end else begin
            int_cnt   <= phase_int_out ? int_cnt + 1 : 0;
            deint_cnt <= phase_deint_out ? deint_cnt + 1 : 0;
            az_cnt    <= phase_az_out ? az_cnt + 1 : 0;
            // Idle auto-zero after reset may be short
            conv_seen <= conv_seen | phase_deint_out;
        end
    end

    logic [RES_BITS+1:0] dis_bits;
    for (genvar i = 0; i < RES_BITS + 2; i++) begin : g_dis
        assign dis_bits[i] = byte_dis_n_out[i / 8];
    end

    // *****
    // Properties
    // *****
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pulse; !chip_off_load_strobe_n ##1 chip_off_load_strobe_n; endsequence
    sequence s_release; !(|data_oe) ##1 (&byte_dis_n_out); endsequence

    property p_strobe; $fell(chip_off_load_strobe_n) |-> s_pulse; endproperty
    property p_strobe_dis; $fell(chip_off_load_strobe_n) |-> $onehot(~byte_dis_n_out); endproperty
    // Ready reaches the sequencer through two synchroniser flops
    property p_rdy; $fell(chip_off_load_strobe_n) |-> $past(receiver_ready_in, 3); endproperty
    property p_oe; !(|(data_oe & dis_bits)); endproperty
    property p_release; $fell(|data_oe) |-> s_release; endproperty
    property p_drive;
        (!(&byte_dis_n_out) || !chip_off_load_strobe_n) |->
            ((&byte_dis_oe) && chip_off_load_strobe_oe);
    endproperty
    property p_int; $fell(phase_int_out) |-> int_cnt == INT_COUNTS; endproperty
    property p_deint; phase_deint_out |-> deint_cnt < DEINT_COUNTS; endproperty
    property p_az; ($rose(phase_int_out) && conv_seen) |-> az_cnt >= AZ_MIN_COUNTS; endproperty
    property p_status; $rose(phase_int_out) |-> $rose(conversion_status_out); endproperty
    property p_status_fall; $fell(conversion_status_out) |-> (phase_az_out && !phase_int_out); endproperty

    a_strobe: assert property (p_strobe) else $error("strobe low not one clock");
    a_strobe_dis: assert property (p_strobe_dis) else $error("strobe without one byte");
    a_rdy: assert property (p_rdy) else $error("byte sent while busy");
    a_oe: assert property (p_oe) else $error("data driven with byte disabled");
    a_release: assert property (p_release) else $error("disable not released");
    a_drive: assert property (p_drive) else $error("handshake pins not driven");
    a_int: assert property (p_int) else $error("integrate length wrong");
    a_deint: assert property (p_deint) else $error("deintegrate too long");
    a_az: assert property (p_az) else $error("auto-zero too short");
    a_status: assert property (p_status) else $error("status rise wrong");
    a_status_fall: assert property (p_status_fall) else $error("status fall wrong");
endmodule : adhr_rc_props

bind adhr_run_control adhr_rc_props #(.RES_BITS(RES_BITS), .INT_COUNTS(INT_COUNTS),
    .DEINT_COUNTS(DEINT_COUNTS), .AZ_MIN_COUNTS(AZ_MIN_COUNTS)) u_props (.*);

// ---- adhr_rx_model.sv ----
// Receiver model: takes one byte per load strobe rising edge.
// Assumes pin levels already resolved, pull-ups included.
`timescale 1ns/10ps

module adhr_rx_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        strobe_n,
    input  wire logic [2:0]  dis_n,
    input  wire logic [17:0] data,
    output logic             ready,
    output logic             got_v,
    output logic [7:0]       got_b
);
    logic       strobe_q;
    logic [1:0] busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_q <= 1'b1;
            busy     <= 2'h0;
            ready    <= 1'b1;
            got_v    <= 1'b0;
            got_b    <= 8'h00;
        end else begin
            strobe_q <= strobe_n;
            got_v    <= strobe_n && !strobe_q;
            if (strobe_n && !strobe_q) begin
                // Disables act as byte identification flags
                got_b <= !dis_n[0] ? data[7:0] : !dis_n[1] ? data[15:8] : {6'h00, data[17:16]};
            end
            // Busy from strobe fall, as the chip sees ready late
            if (!strobe_n && strobe_q) begin
                busy  <= 2'($urandom_range(3));
                ready <= 1'b0;
            end else if (busy != 2'h0) begin
                busy <= busy - 2'h1;
            end else begin
                ready <= 1'b1;
            end
        end
    end
endmodule : adhr_rx_model

// ---- test_adhr_handshake_run_control.sv ----
// Testbench for the run control with a receiver model at the pins.
// Assumes the checker is bound; short phase counts shorten the run.
`timescale 1ns/10ps

module test_adhr_handshake_run_control;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        mode_in, run_hold_in, comparator_in, cross_en, ready, got_v;
    logic        st, az, intg, deint, stb_n, stb_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [17:0] dout, doe, dlast, data_w;
    logic [2:0]  dis_n, dis_oe;
    logic [7:0]  got_b;
    logic [32:0] rq[$];
    logic [7:0]  bq[$];
    int          miscompares, cmp_count, cycles;

    // Released pins: pull-up on disables, changing pattern on data
    assign data_w = (dout & doe) | (~dlast & ~doe);

    adhr_run_control #(.INT_COUNTS(8), .DEINT_COUNTS(16), .AZ_MIN_COUNTS(8)) u_dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_in(mode_in), .run_hold_in(run_hold_in),
        .comparator_in(comparator_in), .receiver_ready_in(ready), .conversion_status_out(st),
        .phase_az_out(az), .phase_int_out(intg), .phase_deint_out(deint), .data_out(dout),
        .data_oe(doe), .byte_dis_n_out(dis_n), .byte_dis_oe(dis_oe),
        .chip_off_load_strobe_n(stb_n), .chip_off_load_strobe_oe(stb_oe));

    adhr_rx_model u_rx (.pclk(pclk), .presetn(presetn), .strobe_n(stb_n | ~stb_oe),
        .dis_n(dis_n | ~dis_oe), .data(data_w), .ready(ready), .got_v(got_v), .got_b(got_b));

    // *****
    // Compare, bus and closing tasks
    // *****
    task cmp(input logic [32:0] g, input logic [32:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [11:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task exp3(input logic [17:0] v, input int n);
        repeat (n) begin
            bq.push_back(v[7:0]);
            bq.push_back(v[15:8]);
            bq.push_back({6'h00, v[17:16]});
        end
    endtask : exp3

    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done

    // *****
    // Clock, monitors, comparator and timeout
    // *****
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        dlast         <= data_w;
        comparator_in <= !(cross_en && deint && $urandom_range(3) == 0);
        cycles        <= cycles + 1;
        if (psel && penable && pready && !pwrite) begin
            if (rq.size() == 0) cmp(0, 1);
            else cmp({pslverr, prdata}, rq.pop_front());
        end
        if (got_v) begin
            if (bq.size() == 0) cmp(0, 1);
            else cmp(got_b, bq.pop_front());
        end
        if (cycles == 20000) begin
            miscompares++;
            test_done;
        end
    end

    // *****
    // Scenarios
    // *****
    initial begin
        {psel, penable, pwrite, paddr, pwdata, mode_in, run_hold_in, cross_en} = '0;
        {comparator_in, dlast, presetn, miscompares, cmp_count, cycles} = '0;
        void'($urandom(11493));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1 cmp({az, st, dis_oe, stb_oe, dis_n, stb_n, |doe}, 33'h41e);
        rd(12'h000, 33'h0);
        rd(12'h00c, 33'h100000000);
        // On demand: one pulse sends the held result, a second is ignored
        exp3(18'h00000, 1);
        @(posedge pclk) mode_in <= 1'b1;
        repeat (4) @(posedge pclk) mode_in <= 1'b0;
        repeat (6) @(posedge pclk) mode_in <= 1'b1;
        repeat (4) @(posedge pclk) mode_in <= 1'b0;
        while (bq.size() > 0) @(posedge pclk);
        repeat (20) @(posedge pclk);
        #1 cmp({dis_oe, stb_oe}, 33'h0);
        // Overload runs, mode held high: a transfer per latched result
        apb(1'b1, 12'h000, 32'h2);
        rd(12'h000, 33'h2);
        @(negedge st);
        exp3(18'h3ffff, 2);
        mode_in <= 1'b1;
        while (bq.size() > 1) @(posedge pclk);
        mode_in <= 1'b0;
        while (bq.size() > 0) @(posedge pclk);
        rd(12'h008, 33'h3ffff);
        apb(1'b1, 12'h000, 32'h0);
        repeat (80) @(posedge pclk);
        #1 cmp({dis_oe, stb_oe, az}, 33'h1);
        // Crossings with a restless run/hold pin
        cross_en <= 1'b1;
        repeat (600) @(posedge pclk) run_hold_in <= 1'($urandom_range(1));
        test_done;
    end
endmodule : test_adhr_handshake_run_control
